// *** rtl/sor_pkg.sv ***
`default_nettype none

package sor_pkg;

    // Register map, word offsets on the holding-register port
    localparam logic [15:0] SOR_OFS_GROUP0 = 16'h0000;
    localparam logic [15:0] SOR_OFS_GROUP1 = 16'h0001;
    localparam logic [15:0] SOR_OFS_GROUP2 = 16'h0002;
    localparam logic [15:0] SOR_OFS_GROUP3 = 16'h0003;

    // Geometry
    localparam int SOR_GROUPS = 4;
    localparam int SOR_CHANNELS = 16;
    localparam int SOR_REG_W = 16;

    // Field layout: channel 4n+k sits in bit k of word n
    localparam int SOR_FIELD_LSB = 0;
    localparam int SOR_FIELD_W = 4;
    localparam logic [15:0] SOR_FIELD_MASK = 16'h000f;

    // Reset value of each output word, all channels off
    localparam logic [15:0] SOR_RESET_VAL = 16'h0000;

    // Timeout state of the sixteen gates, default all off
    localparam logic [15:0] SOR_TIMEOUT_GATES = 16'h0000;

    // Connection supervision states
    typedef enum logic [1:0] {
        SOR_CONN_IDLE,
        SOR_CONN_ACTIVE,
        SOR_CONN_TIMEOUT
    } sor_conn_t;

endpackage

`default_nettype wire

// *** rtl/sor_readback.sv ***
`default_nettype none

module sor_readback (
    input wire logic clock,
    input wire logic nrst,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    input wire logic [15:0] gates,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_err
);
    import sor_pkg::*;

    logic [15:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic rd_err_q, rd_err_d;

    ////////////////////////////////////////////////////////////////////////
    // Next read word: stored gate command only, upper bits forced low
    always_comb begin
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        rd_err_d = 1'b0;
        if (rd_en) begin
            rd_valid_d = 1'b1;
            if (rd_addr < 16'(SOR_GROUPS)) begin
                // Gate command, not drain level
                rd_data_d = 16'(gates[rd_addr[1:0] * SOR_FIELD_W +: SOR_FIELD_W]);
            end else begin
                rd_data_d = 16'h0000;
                rd_err_d = 1'b1;
            end
        end
    end

    // Registered read answer
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            rd_err_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            rd_err_q <= rd_err_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign rd_err = rd_err_q;

endmodule

`default_nettype wire

// *** rtl/sor_output_bank.sv ***
// Contract
// - Lost established connection raises watchdog timeout
// - Only reconnection or a reset clears a pending timeout
// - Outputs keep timeout state after timeout clears
// - Stored bit directly drives one output gate
// - Word n holds channels 4n..4n+3, low first
// - Bits 15 to 4 unused, read zero
// - One switches channel on, zero opens it
// - Any reset clears all four output words
// - Contents volatile, nothing restored at power-up
// - Input inversion never touches output control
// - Readback returns gate command, not drain level
`default_nettype none

module sor_output_bank (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    output logic wr_err,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_err,
    input wire logic refresh_en,
    input wire logic [15:0] refresh_gates,
    input wire logic conn_up,
    output logic timeout_active,
    output logic [15:0] gate_cmd,
    output logic [15:0] gate_oe_n
);
    import sor_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word offset maps onto a group
    function automatic logic addr_hit(input logic [15:0] addr);
        addr_hit = (addr >= SOR_OFS_GROUP0) && (addr <= SOR_OFS_GROUP3);
    endfunction

    // Replace one group's nibble in the sixteen-gate vector
    function automatic logic [15:0] put_group(
        input logic [15:0] gates,
        input logic [1:0] grp,
        input logic [15:0] word
    );
        logic [15:0] res;
        res = gates;
        res[grp * SOR_FIELD_W +: SOR_FIELD_W] = word[SOR_FIELD_LSB +: SOR_FIELD_W];
        put_group = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Connection supervision

    sor_conn_t conn_q, conn_d;
    logic force_timeout;

    // A timeout needs a connection that was once up; idle never times out
    always_comb begin
        conn_d = conn_q;
        force_timeout = 1'b0;
        unique case (conn_q)
            SOR_CONN_IDLE: begin
                if (conn_up) begin
                    conn_d = SOR_CONN_ACTIVE;
                end
            end
            SOR_CONN_ACTIVE: begin
                if (!conn_up) begin
                    conn_d = SOR_CONN_TIMEOUT;
                    force_timeout = 1'b1;
                end
            end
            SOR_CONN_TIMEOUT: begin
                // Nothing but a fresh connection or a reset leaves here
                if (conn_up) begin
                    conn_d = SOR_CONN_ACTIVE;
                end
            end
        endcase
    end

    // Supervision state register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            conn_q <= SOR_CONN_IDLE;
        end else begin
            conn_q <= conn_d;
        end
    end

    assign timeout_active = (conn_q == SOR_CONN_TIMEOUT);

    ////////////////////////////////////////////////////////////////////////
    // Output holding words, kept as one sixteen-gate vector

    logic [15:0] gates_q, gates_d;
    logic wr_err_q, wr_err_d;
    logic wr_ok;

    // Writes while timed out are refused so the safe state holds
    assign wr_ok = wr_en && addr_hit(wr_addr) && !timeout_active;

    // Priority: forced timeout, then bus write, then auto refresh
    always_comb begin
        gates_d = gates_q;
        wr_err_d = 1'b0;
        if (force_timeout) begin
            gates_d = SOR_TIMEOUT_GATES;
        end else if (wr_ok) begin
            gates_d = put_group(gates_q, wr_addr[1:0], wr_data);
        end else if (refresh_en && !timeout_active) begin
            gates_d = refresh_gates;
        end
        // Leaving timeout restores nothing: the vector just stays
        if (wr_en && !wr_ok) begin
            wr_err_d = 1'b1;
        end
    end

    // Plain flops, no preload from storage of any kind
    always_ff @(posedge clock) begin
        if (!nrst) begin
            gates_q <= {SOR_GROUPS{SOR_RESET_VAL[SOR_FIELD_LSB +: SOR_FIELD_W]}};
            wr_err_q <= 1'b0;
        end else begin
            gates_q <= gates_d;
            wr_err_q <= wr_err_d;
        end
    end

    assign wr_err = wr_err_q;

    ////////////////////////////////////////////////////////////////////////
    // Gate drive: a set bit closes the switch to switch_return_node

    // Each stored bit is the gate command of its channel
    assign gate_cmd = gates_q;
    // Enable low while the channel sinks; high leaves the drain open
    assign gate_oe_n = ~gates_q;

    ////////////////////////////////////////////////////////////////////////
    // Readback of the stored command; no input inversion path exists here

    sor_readback u_readback (
        .clock(clock),
        .nrst(nrst),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .gates(gates_q),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .rd_err(rd_err)
    );

endmodule

`default_nettype wire

// *** tb/sor_output_bank_asserts.sv ***
`default_nettype none
module sor_asserts (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_err,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_err,
    input wire logic conn_up,
    input wire logic timeout_active,
    input wire logic [15:0] gate_cmd,
    input wire logic [15:0] gate_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_OE: assert property (gate_oe_n == ~gate_cmd)
        else $error("bad oe");
    AST_RDV: assert property (rd_en |=> rd_valid)
        else $error("no rd_valid");
    AST_RB: assert property (rd_en && rd_addr < 16'h4 |=>
        rd_data == (($past(gate_cmd) >> (4 * $past(rd_addr[1:0]))) & 16'hf))
        else $error("bad readback");
    AST_RDE: assert property (rd_en && rd_addr > 16'h3 |=> rd_err && rd_data == 16'h0)
        else $error("bad unmapped read");
    AST_WR: assert property (wr_en && wr_addr < 16'h4 && conn_up && !timeout_active |=>
        ((gate_cmd >> (4 * $past(wr_addr[1:0]))) & 16'hf) == ($past(wr_data) & 16'hf))
        else $error("write lost");
    AST_WERR: assert property (wr_en && wr_addr > 16'h3 |=> wr_err)
        else $error("no wr_err");
    AST_TOG: assert property (timeout_active |-> gate_cmd == 16'h0)
        else $error("gates on in timeout");
    AST_TOH: assert property (timeout_active && !conn_up |=> timeout_active)
        else $error("timeout cleared early");
    AST_TOC: assert property (timeout_active && conn_up |=> !timeout_active && gate_cmd == 16'h0)
        else $error("bad timeout clear");
    AST_RST: assert property (disable iff (1'b0) !nrst |=> gate_cmd == 16'h0)
        else $error("reset left gates");
    // Main scenarios seen
    cover property (timeout_active && conn_up);
    cover property (rd_err);
    cover property (wr_err);
endmodule
bind sor_output_bank sor_asserts i_chk (
    .clock(clock),
    .nrst(nrst),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .rd_err(rd_err),
    .conn_up(conn_up),
    .timeout_active(timeout_active),
    .gate_cmd(gate_cmd),
    .gate_oe_n(gate_oe_n)
);
`default_nettype wire

// *** tb/sor_client.sv ***
`default_nettype none
module sor_client (
    input wire logic clock,
    input wire logic link_ok,
    output logic conn_up
);
    timeunit 1ns;
    timeprecision 1ps;
    // Drain level is left to the input words; this client only drives conn_up
    // Session follows the cable one clock late; a drop models a break
    always_ff @(posedge clock) conn_up <= link_ok;
endmodule
`default_nettype wire

// *** tb/sor_output_bank_tb.sv ***
`default_nettype none
module sor_output_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = '0, nrst = '0, wr_en = '0, rd_en = '0, refresh_en = '0, link = '0;
    logic [15:0] wr_addr = '0, wr_data = '0, rd_addr = '0, refresh_gates = '0, m = '0;
    logic [15:0] rd_data, gate_cmd, gate_oe_n, q[$];
    logic qe[$];
    logic wr_err, rd_valid, rd_err, conn_up, timeout_active;
    int fail_count = 0, n_compared = 0, seed = 32'h3bff041d, a;
    always #12.5 clock = ~clock;
    sor_client i_cli (.clock(clock), .link_ok(link), .conn_up(conn_up));
    sor_output_bank i_dut (
        .clock(clock),
        .nrst(nrst),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .rd_err(rd_err),
        .refresh_en(refresh_en),
        .refresh_gates(refresh_gates),
        .conn_up(conn_up),
        .timeout_active(timeout_active),
        .gate_cmd(gate_cmd),
        .gate_oe_n(gate_oe_n)
    );
    task automatic chk(logic [15:0] s, logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Model tracks accepted writes only; refused ones leave it alone
    task automatic wr(logic [15:0] ad, logic [15:0] d);
        logic ok;
        @(posedge clock);
        {wr_en, wr_addr, wr_data} <= {1'b1, ad, d};
        ok = (ad < 16'h4) && !timeout_active;
        if (ok) m[ad * 4 +: 4] = d[3:0];
        @(posedge clock);
        wr_en <= 1'b0;
        #1 chk(gate_cmd, m);
        chk(gate_oe_n, ~m);
        chk({15'h0, wr_err}, {15'h0, !ok});
    endtask
    task automatic rd(logic [15:0] ad);
        @(posedge clock);
        {rd_en, rd_addr} <= {1'b1, ad};
        q.push_back(ad < 16'h4 ? (m >> (ad * 4)) & 16'hf : 16'h0);
        qe.push_back(ad > 16'h3);
        @(posedge clock);
        rd_en <= 1'b0;
    endtask
    // Results come back one cycle later, oldest note first
    always @(negedge clock) begin
        if (rd_valid === 1'b1) begin
            chk(rd_data, q.pop_front());
            chk({15'h0, rd_err}, {15'h0, qe.pop_front()});
        end
    end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        {nrst, link} <= 2'h3;
        for (int i = 0; i < 12; i++) begin
            a = {$random(seed)} % 5;
            wr(a[15:0], 16'($random(seed)));
            rd(a[15:0]);
        end
        // Unmapped offsets are refused whatever the random draw gave
        wr(16'h4, 16'hffff);
        rd(16'h7);
        @(posedge clock) {refresh_en, refresh_gates} <= {1'b1, 16'ha5c3};
        @(posedge clock) refresh_en <= 1'b0;
        m = 16'ha5c3;
        #1 chk(gate_cmd, m);
        @(posedge clock) link <= 1'b0;
        repeat (4) @(posedge clock);
        m = 16'h0;
        chk(timeout_active, 16'h1);
        wr(16'h2, 16'hf);
        rd(16'h2);
        // Refresh while timed out must not lift the safe state
        @(posedge clock) {refresh_en, refresh_gates} <= {1'b1, 16'hffff};
        @(posedge clock) refresh_en <= 1'b0;
        #1 chk(gate_cmd, 16'h0);
        @(posedge clock) link <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk(timeout_active, 16'h0);
        chk(gate_cmd, 16'h0);
        wr(16'h3, 16'h9);
        @(posedge clock) nrst <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(gate_cmd, 16'h0);
        // Release the mid-run reset and read back the cleared word
        m = 16'h0;
        @(posedge clock) nrst <= 1'b1;
        rd(16'h3);
        repeat (2) @(posedge clock);
        report_and_stop;
    end
    initial begin
        #50000;
        fail_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
